//--- sdlc_pkg.sv
// -----------------------------------------------------------------------------
// shared constants of the serial converter load control
// -----------------------------------------------------------------------------
package sdlc_pkg;

	// word layout
	localparam int DATA_W = 16;
	localparam logic [15:0] MIDSCALE = 16'h8000; // half scale, zero volts
	localparam logic [4:0] FRAME_BITS = 5'h10; // serial clocks per word
	localparam logic [4:0] CNT_RESET = 5'h00;

	// buffering between the shifter and the input register
	localparam int FIFO_DEPTH = 4;

	// pin synchroniser: {power_down_n, output_clear_n, load_strobe_n, data, clk, frame}
	localparam int PIN_W = 6;
	localparam logic [5:0] PIN_RESET = 6'h3F; // every pin idles high
	localparam int PIN_FRAME = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_LOAD = 3;
	localparam int PIN_CLEAR = 4;
	localparam int PIN_PDOWN = 5;

	// timing: the fastest serial clock the host may use against our sampling clock
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCLK_MIN_PERIOD_NS = 125;
	localparam int SCLK_MIN_CYCLES = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : sdlc_pkg

//--- sdlc_sync.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// two flip-flop synchroniser for a group of pins
// -----------------------------------------------------------------------------
module sdlc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// first stage is read only by the second one
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			meta_q <= RST_VAL;
			stable_q <= RST_VAL;
		end else begin
			meta_q <= async_i;
			stable_q <= meta_q;
		end
	end

	assign sync_o = stable_q;

endmodule : sdlc_sync

//--- sdlc_fifo.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// small word fifo with valid/ready on both sides
// -----------------------------------------------------------------------------
module sdlc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	// honest flags straight from the fill count
	assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// pointer and storage next state
	always_comb begin
		wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
		rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = (PW+1)'(cnt_q + 1'b1);
		end else if (pop && !push) begin
			cnt_d = (PW+1)'(cnt_q - 1'b1);
		end
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = (push && wr_q == PW'(i)) ? in_data_i : mem_q[i];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			mem_q <= mem_d;
		end
	end

endmodule : sdlc_fifo

//--- sdlc_top.sv
// Overview of operation
// RULE1: clear forces output to ground, registers kept
// RULE2: load strobe copies input into DAC register
// RULE3: strobe held low: update at frame end
// RULE4: frame low enables shifting for sixteen clocks; the code keeps shifting past the sixteenth while frame stays low
// RULE5: data sampled on serial clock falling edge
// RULE6: host keeps serial clock at most 8 MHz
// RULE7: words held in sixteen bit shift register
// RULE8: shift register contents shown on serial output
// RULE9: serial output only pulls low, external pull-up
// RULE10: power-down input low enters low-power state
// RULE11: straight binary, zero code is negative full-scale
// RULE12: all ones is positive full-scale less one
// RULE13: code 0x8000 gives zero volts
// RULE14: serial pins ignored while frame is high
// RULE15: reset loads midscale into shift and DAC
// RULE16: frame end moves word into input register
// RULE17: strobe high while shifting: update on later fall
// RULE18: after clear, hold ground until next strobe
// RULE19: serial output carries bit leaving the top
`timescale 1ns/100ps
module sdlc_top (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic frame_sync_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_data_in_i,
	input wire logic load_strobe_n_i,
	input wire logic output_clear_n_i,
	input wire logic power_down_n_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	output logic [15:0] dac_code_o,
	output logic [15:0] dac_offset_o,
	output logic out_clamp_o,
	output logic power_down_o,
	output logic frame_ready_o
);

	// -------------------------------------------------------------------------
	// pin synchronisation and edge detection
	// -------------------------------------------------------------------------
	logic [5:0] pins_raw;
	logic [5:0] pins_s;
	logic frame_s, sclk_s, sdi_s, load_s, clear_s, awake_s;
	logic sclk_prev_q, sclk_prev_d, frame_prev_q, frame_prev_d, load_prev_q, load_prev_d;
	logic clear_prev_q, clear_prev_d;
	logic sclk_fall, in_frame, frame_end, load_fall, clear_fall;

	assign pins_raw = {power_down_n_i, output_clear_n_i, load_strobe_n_i,
		serial_data_in_i, serial_clk_i, frame_sync_n_i};

	// every pin comes from the host's domain, so all of them pass two flops
	sdlc_sync #(
		.WIDTH(sdlc_pkg::PIN_W),
		.RST_VAL(sdlc_pkg::PIN_RESET)
	) u_pin_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.async_i(pins_raw),
		.sync_o(pins_s)
	);

	assign frame_s = pins_s[sdlc_pkg::PIN_FRAME];
	assign sclk_s = pins_s[sdlc_pkg::PIN_SCLK];
	assign sdi_s = pins_s[sdlc_pkg::PIN_SDI];
	assign load_s = pins_s[sdlc_pkg::PIN_LOAD];
	assign clear_s = pins_s[sdlc_pkg::PIN_CLEAR];
	assign awake_s = pins_s[sdlc_pkg::PIN_PDOWN];

	// edge history of the synchronised pins
	always_comb begin
		sclk_prev_d = sclk_s;
		frame_prev_d = frame_s;
		load_prev_d = load_s;
		clear_prev_d = clear_s;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sclk_prev_q <= 1'b1;
			frame_prev_q <= 1'b1;
			load_prev_q <= 1'b1;
			clear_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_prev_d;
			frame_prev_q <= frame_prev_d;
			load_prev_q <= load_prev_d;
			clear_prev_q <= clear_prev_d;
		end
	end

	// one decode for every falling pin, so all strobes follow the same edge rule
	function automatic logic falling(input logic prev_v, input logic now_v);
		return prev_v & ~now_v;
	endfunction : falling

	// edge detection needs each serial clock phase to last a sampling cycle or more
	assign in_frame = ~frame_s; // see RULE4
	assign sclk_fall = falling(sclk_prev_q, sclk_s) & in_frame; // see RULE5 see RULE6 see RULE14
	assign frame_end = ~frame_prev_q & frame_s;
	assign load_fall = falling(load_prev_q, load_s);
	assign clear_fall = falling(clear_prev_q, clear_s);

	// -------------------------------------------------------------------------
	// input shift register and open-drain serial output
	// -------------------------------------------------------------------------
	logic [15:0] shift_q, shift_d;
	logic [4:0] cnt_q, cnt_d;
	logic sdo_oe_q, sdo_oe_d;

	// bits past the sixteenth keep shifting so a daisy chain passes through
	always_comb begin
		shift_d = shift_q;
		cnt_d = cnt_q;
		if (!in_frame) begin
			cnt_d = sdlc_pkg::CNT_RESET;
		end else if (sclk_fall) begin
			shift_d = {shift_q[14:0], sdi_s}; // see RULE5 see RULE7
			if (cnt_q != sdlc_pkg::FRAME_BITS) begin
				cnt_d = 5'(cnt_q + 1'b1); // see RULE4
			end
		end
		sdo_oe_d = ~shift_d[15]; // see RULE8 see RULE19 see RULE9
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			shift_q <= sdlc_pkg::MIDSCALE; // see RULE15
			cnt_q <= sdlc_pkg::CNT_RESET;
			sdo_oe_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			sdo_oe_q <= sdo_oe_d;
		end
	end

	assign serial_data_out_o = 1'b0; // only ever pulls low, see RULE9
	assign serial_data_out_oe_o = sdo_oe_q;

	// -------------------------------------------------------------------------
	// word buffer between the shifter and the input register
	// -------------------------------------------------------------------------
	logic push, fifo_in_ready, fifo_out_valid, drain;
	logic [15:0] fifo_data;

	// a word that finds the buffer full is dropped; frame_ready_o warns the host
	assign push = frame_end & (cnt_q == sdlc_pkg::FRAME_BITS); // see RULE16
	assign drain = fifo_out_valid & awake_s;
	assign frame_ready_o = fifo_in_ready;

	sdlc_fifo #(
		.WIDTH(sdlc_pkg::DATA_W),
		.DEPTH(sdlc_pkg::FIFO_DEPTH)
	) u_word_fifo (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(shift_q),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(awake_s),
		.out_data_o(fifo_data)
	);

	// -------------------------------------------------------------------------
	// input register, DAC register, clear and power-down
	// -------------------------------------------------------------------------
	logic [15:0] in_q, in_d, dac_q, dac_d, code_q, code_d, offset_q, offset_d;
	logic upd_pend_q, upd_pend_d, hold_q, hold_d, pdown_q, pdown_d;
	logic upd_req, upd_go;

	// synchronous mode at frame end, or a strobe fall outside a frame
	assign upd_req = (frame_end & ~load_s) | (load_fall & frame_s); // see RULE3 see RULE17
	// wait until every buffered word has reached the input register
	assign upd_go = upd_pend_q & ~fifo_out_valid & ~push;

	always_comb begin
		in_d = drain ? fifo_data : in_q; // see RULE16
		dac_d = upd_go ? in_q : dac_q; // see RULE2
		upd_pend_d = upd_req | (upd_pend_q & ~upd_go);
		// clear wins over a release in the same cycle
		hold_d = ~clear_s | (hold_q & ~upd_go); // see RULE1 see RULE18
		code_d = hold_d ? sdlc_pkg::MIDSCALE : dac_d; // see RULE1 see RULE13
		offset_d = code_d ^ sdlc_pkg::MIDSCALE; // see RULE11 see RULE12
		pdown_d = ~awake_s; // see RULE10
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			in_q <= sdlc_pkg::MIDSCALE;
			dac_q <= sdlc_pkg::MIDSCALE; // see RULE15
			code_q <= sdlc_pkg::MIDSCALE;
			offset_q <= 16'h0000;
			upd_pend_q <= 1'b0;
			hold_q <= 1'b0;
			pdown_q <= 1'b0;
		end else begin
			in_q <= in_d;
			dac_q <= dac_d;
			code_q <= code_d;
			offset_q <= offset_d;
			upd_pend_q <= upd_pend_d;
			hold_q <= hold_d;
			pdown_q <= pdown_d;
		end
	end

	assign dac_code_o = code_q;
	assign dac_offset_o = offset_q;
	assign out_clamp_o = hold_q;
	assign power_down_o = pdown_q;

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_sync_frame_end;
		frame_end && !load_s && awake_s;
	endsequence

	sequence s_shift_step;
		sclk_fall && in_frame;
	endsequence

	// a strobe fall taken while the frame is high
	sequence s_async_strobe;
		load_fall && frame_s;
	endsequence

	AST_CLEAR_TO_GROUND: assert property (clear_fall |=> // see RULE1
		out_clamp_o && dac_code_o == 16'h8000)
		else $error("clear did not force the output to ground");

	AST_CLEAR_KEEPS_REGS: assert property (clear_fall && !upd_go && !drain |=> // see RULE1
		dac_q == $past(dac_q) && in_q == $past(in_q))
		else $error("clear disturbed the registers");

	AST_LOAD_COPIES: assert property (upd_go |=> dac_q == $past(in_q)) // see RULE2
		else $error("update did not copy the input register");

	AST_SYNC_MODE_UPDATE: assert property (s_sync_frame_end |-> // see RULE3
		##[1:4] (upd_go || !awake_s))
		else $error("frame end with strobe low gave no update");

	AST_SHIFT_ON_FALL: assert property (s_shift_step |=> // see RULE5
		shift_q == {$past(shift_q[14:0]), $past(sdi_s)})
		else $error("serial data not shifted on the falling edge");

	AST_COUNT_SIXTEEN: assert property ((s_shift_step and (cnt_q == 5'h0F)) |=> // see RULE4
		cnt_q == 5'h10)
		else $error("bit count did not reach sixteen");

	AST_FRAME_HIGH_IDLE: assert property (frame_s |=> // see RULE14
		shift_q == $past(shift_q) && cnt_q == 5'h00)
		else $error("serial pins changed state outside a frame");

	AST_SDO_TOP_BIT: assert property (s_shift_step |=> // see RULE19
		serial_data_out_oe_o == !$past(shift_q[14]))
		else $error("serial output does not carry the leaving bit");

	AST_SDO_OPEN_DRAIN: assert property (serial_data_out_o == 1'b0) // see RULE9
		else $error("serial output drove high");

	AST_POWER_DOWN: assert property (!awake_s |=> power_down_o) // see RULE10
		else $error("power-down input ignored");

	AST_CODE_MAP: assert property (dac_offset_o == (dac_code_o ^ 16'h8000)) // see RULE11
		else $error("output code not straight binary");

	AST_CLEAR_HOLDS: assert property (out_clamp_o && !upd_go |=> out_clamp_o) // see RULE18
		else $error("clear released without a strobe");

	AST_WORD_TO_INPUT: assert property (push && fifo_in_ready && awake_s |-> // see RULE16
		##[1:6] in_q == $past(shift_q))
		else $error("word did not reach the input register");

	// the reset check must not be switched off by the very reset it watches
	AST_MIDSCALE_RESET: assert property (@(posedge mclk_i) disable iff (1'b0) // see RULE15
		!rst_n_i |=> shift_q == 16'h8000 && dac_q == 16'h8000)
		else $error("reset did not load midscale");

	AST_ASYNC_LOAD: assert property (s_async_strobe |-> // see RULE17
		##[1:6] (upd_go || !awake_s))
		else $error("strobe fall after the frame gave no update");

	AST_STROBE_IN_FRAME: assert property (load_fall && !frame_s && !upd_pend_q |=> // see RULE17
		!upd_pend_q)
		else $error("strobe inside a frame started an update");

	AST_POWER_UP: assert property (awake_s |=> !power_down_o) // see RULE10
		else $error("power-down output stuck after release");

	AST_SDO_SHOWS_SHIFT: assert property (serial_data_out_oe_o == !shift_q[15]) // see RULE8
		else $error("serial output does not show the shift register");

	AST_CODE_FOLLOWS_DAC: assert property (!out_clamp_o |-> dac_code_o == dac_q) // see RULE2
		else $error("output code differs from the DAC register");

	AST_CLAMP_MIDSCALE: assert property (out_clamp_o |-> dac_code_o == 16'h8000) // see RULE18
		else $error("clamped output not at zero volts");

	AST_NEG_FULL_SCALE: assert property (dac_code_o == 16'h0000 |-> // see RULE11
		dac_offset_o == 16'h8000)
		else $error("all zeros code not at negative full scale");

	AST_POS_FULL_SCALE: assert property (dac_code_o == 16'hFFFF |-> // see RULE12
		dac_offset_o == 16'h7FFF)
		else $error("all ones code not at positive full scale");

	AST_HALF_SCALE: assert property (dac_code_o == 16'h8000 |-> // see RULE13
		dac_offset_o == 16'h0000)
		else $error("half scale code not at zero volts");

endmodule : sdlc_top

//--- sdlc_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host end of the serial link, with the pull-up on the serial output
// ----------------------------------------
module sdlc_host (
	input wire logic mclk_i,
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	output logic frame_sync_n_o,
	output logic serial_clk_o,
	output logic serial_data_o
);
	logic sdo_pin;

	// the pin only goes low while the device pulls it; otherwise the resistor wins
	assign sdo_pin = sdo_oe_i ? sdo_i : 1'b1;

	// idle: frame high, clock parked high
	initial begin
		frame_sync_n_o = 1'b1;
		serial_clk_o = 1'b1;
		serial_data_o = 1'b0;
	end

	// move n clock edges on, then just past the edge
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : step

	// one word msb first; four cycles a phase gives a 320 ns period, inside the 8 MHz ceiling
	task automatic send(input logic [15:0] word, output logic [15:0] back);
		frame_sync_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_data_o = word[i];
			step(4);
			back[i] = sdo_pin;
			serial_clk_o = 1'b0;
			step(4);
			serial_clk_o = 1'b1;
		end
		step(1);
		frame_sync_n_o = 1'b1;
		serial_data_o = ~word[0]; // released line must not keep a stale bit
		step(3);
	endtask : send

	// clock and data wiggle with the frame held high; n even leaves the clock high
	task automatic noise(input int n);
		for (int i = 0; i < n; i++) begin
			serial_clk_o = ~serial_clk_o;
			serial_data_o = ~serial_data_o;
			step(4);
		end
	endtask : noise

endmodule : sdlc_host

//--- testbench.sv
`timescale 1ns/100ps
// ----------------------------------------
// self-checking bench for the load control
// ----------------------------------------
module testbench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic load_n = 1'b1;
	logic clear_n = 1'b1;
	logic pdown_n = 1'b1;
	logic frame_n, sclk, sdi, serial_data_out, sdo_oe, pd, clamp, ready;
	logic [15:0] code, offset, back, prev;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;

	// 25 MHz system clock
	always #20 mclk = ~mclk;

	sdlc_host host_u (.mclk_i(mclk), .sdo_i(serial_data_out), .sdo_oe_i(sdo_oe),
		.frame_sync_n_o(frame_n), .serial_clk_o(sclk), .serial_data_o(sdi));

	sdlc_top dut_u (.mclk_i(mclk), .rst_n_i(rst_n), .frame_sync_n_i(frame_n),
		.serial_clk_i(sclk), .serial_data_in_i(sdi), .load_strobe_n_i(load_n),
		.output_clear_n_i(clear_n), .power_down_n_i(pdown_n), .serial_data_out_o(serial_data_out),
		.serial_data_out_oe_o(sdo_oe), .dac_code_o(code), .dac_offset_o(offset),
		.out_clamp_o(clamp), .power_down_o(pd), .frame_ready_o(ready));

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// strobe low long enough for the synchroniser, then back high
	task automatic pulse_load();
		load_n = 1'b0;
		step(4);
		load_n = 1'b1;
		step(4);
	endtask : pulse_load

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// a hang costs a mismatch; the whole run needs under two thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("ERROR timeout expected done seen %0d cycles", cycles);
			conclude();
		end
	end

	task automatic t_reset();
		chk("code", 16'h8000, code);
		chk("offset", 16'h0000, offset);
		chk("sdo oe", 16'h0000, {15'h0000, sdo_oe});
		chk("sdo value", 16'h0000, {15'h0000, serial_data_out});
		chk("clamp", 16'h0000, {15'h0000, clamp});
		chk("pd", 16'h0000, {15'h0000, pd});
		chk("ready", 16'h0001, {15'h0000, ready});
		$display("test reset done");
	endtask : t_reset

	// strobe high while shifting: nothing moves until the strobe falls afterwards
	task automatic t_async();
		host_u.send(16'hA5C3, back);
		chk("readback", 16'h8000, back);
		step(10);
		chk("code held", 16'h8000, code);
		pulse_load();
		chk("code", 16'hA5C3, code);
		chk("offset", 16'h25C3, offset);
		$display("test async done");
	endtask : t_async

	// strobe tied low: each frame end updates; both ends of the code range
	task automatic t_sync();
		load_n = 1'b0;
		step(4);
		host_u.send(16'h0000, back);
		step(10);
		chk("readback", 16'hA5C3, back);
		chk("code", 16'h0000, code);
		chk("offset", 16'h8000, offset);
		host_u.send(16'hFFFF, back);
		step(10);
		chk("code", 16'hFFFF, code);
		chk("offset", 16'h7FFF, offset);
		$display("test sync done");
	endtask : t_sync

	// link activity with the frame high must not reach shifter or output
	task automatic t_quiet();
		host_u.noise(8);
		step(8);
		chk("code", 16'hFFFF, code);
		host_u.send(16'h1234, back);
		step(10);
		chk("readback", 16'hFFFF, back);
		chk("code", 16'h1234, code);
		$display("test quiet done");
	endtask : t_quiet

	task automatic t_clear();
		load_n = 1'b1;
		step(4);
		clear_n = 1'b0;
		step(4);
		chk("clamp", 16'h0001, {15'h0000, clamp});
		chk("code", 16'h8000, code);
		clear_n = 1'b1;
		step(6);
		chk("clamp", 16'h0001, {15'h0000, clamp});
		chk("code", 16'h8000, code);
		pulse_load();
		chk("clamp", 16'h0000, {15'h0000, clamp});
		chk("code", 16'h1234, code);
		$display("test clear done");
	endtask : t_clear

	// powered down the buffer cannot drain: four words fill it, the fifth is dropped
	task automatic t_pdown();
		pdown_n = 1'b0;
		step(4);
		chk("pd", 16'h0001, {15'h0000, pd});
		prev = 16'h1234;
		for (int i = 1; i <= 5; i++) begin
			host_u.send(16'h0F00 + 16'(i), back);
			chk("readback", prev, back);
			prev = 16'h0F00 + 16'(i);
		end
		step(4);
		chk("ready", 16'h0000, {15'h0000, ready});
		pdown_n = 1'b1;
		step(12);
		chk("pd", 16'h0000, {15'h0000, pd});
		chk("ready", 16'h0001, {15'h0000, ready});
		pulse_load();
		chk("code", 16'h0F04, code);
		$display("test pdown done");
	endtask : t_pdown

	// a second reset mid-run brings back midscale; a strobe inside a frame is ignored
	task automatic t_rerst();
		rst_n = 1'b0;
		step(10);
		rst_n = 1'b1;
		step(3);
		chk("code", 16'h8000, code);
		host_u.send(16'h5A5A, back);
		chk("readback", 16'h8000, back);
		fork
			host_u.send(16'h3C3C, back);
			begin
				step(40);
				pulse_load();
			end
		join
		step(10);
		chk("readback", 16'h5A5A, back);
		chk("code held", 16'h8000, code);
		pulse_load();
		chk("code", 16'h3C3C, code);
		$display("test rerst done");
	endtask : t_rerst

	// reset for ten cycles, then let the pin synchroniser settle
	initial begin
		repeat (10) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		step(3);
		t_reset();
		t_async();
		t_sync();
		t_quiet();
		t_clear();
		t_pdown();
		t_rerst();
		conclude();
	end

endmodule : testbench
